// ==== shared/cit_pkg.sv ====
// Purpose: Shared constants and opcode timing tables for the instruction timing block.
// Assumes: Standard 8051 opcode map; entries packed as {cond, length[1:0], cycles[3:0]}.
// Notes: Table index is the high opcode nibble; the low nibble picks the table.
package cit_pkg;
	// ==========================================================
	// Widths and small constants
	localparam int CIT_LEN_W = 2;
	localparam int CIT_CYC_W = 4;
	localparam logic [CIT_LEN_W-1:0] CIT_LEN_1 = 2'h1;
	localparam logic [CIT_LEN_W-1:0] CIT_LEN_2 = 2'h2;
	localparam logic [CIT_LEN_W-1:0] CIT_LEN_3 = 2'h3;
	localparam logic [CIT_CYC_W-1:0] CIT_CYC_0 = 4'h0;
	localparam logic [CIT_CYC_W-1:0] CIT_CYC_1 = 4'h1;
	localparam logic [CIT_CYC_W-1:0] CIT_CYC_2 = 4'h2;
	localparam logic [CIT_CYC_W-1:0] CIT_CYC_3 = 4'h3;
	localparam logic [CIT_CYC_W-1:0] CIT_CYC_4 = 4'h4;
	localparam logic [CIT_CYC_W-1:0] CIT_CYC_8 = 4'h8;
	localparam logic [7:0] CIT_OP_ALIAS_NOP = 8'ha5;
	// ==========================================================
	// Low-nibble classes
	localparam logic [3:0] CIT_LO_BRANCH = 4'h0;
	localparam logic [3:0] CIT_LO_ABS = 4'h1;
	localparam logic [3:0] CIT_LO_LONG = 4'h2;
	localparam logic [3:0] CIT_LO_MISC = 4'h3;
	localparam logic [3:0] CIT_LO_IMM = 4'h4;
	localparam logic [3:0] CIT_LO_DIRECT = 4'h5;
	localparam logic [2:0] CIT_LO_INDIRECT = 3'h3;
	// ==========================================================
	// Timing tables
	typedef logic [6:0] cit_entry_t;
	typedef enum {CIT_IDLE, CIT_EXEC, CIT_EXTRA} cit_state_t;
	localparam cit_entry_t CIT_TBL_N0 [16] = '{7'h11, 7'h73, 7'h73, 7'h73, 7'h62, 7'h62,
		7'h62, 7'h62, 7'h23, 7'h33, 7'h22, 7'h22, 7'h22, 7'h22, 7'h13, 7'h13};
	localparam cit_entry_t CIT_TBL_N1 [16] = '{default: 7'h23};
	localparam cit_entry_t CIT_TBL_N2 [16] = '{7'h34, 7'h34, 7'h15, 7'h15, 7'h22, 7'h22,
		7'h22, 7'h22, 7'h22, 7'h22, 7'h22, 7'h22, 7'h22, 7'h22, 7'h13, 7'h13};
	localparam cit_entry_t CIT_TBL_N3 [16] = '{7'h11, 7'h11, 7'h11, 7'h11, 7'h33, 7'h33,
		7'h33, 7'h13, 7'h13, 7'h13, 7'h11, 7'h11, 7'h11, 7'h11, 7'h13, 7'h13};
	localparam cit_entry_t CIT_TBL_N4 [16] = '{7'h11, 7'h11, 7'h22, 7'h22, 7'h22, 7'h22,
		7'h22, 7'h22, 7'h18, 7'h22, 7'h14, 7'h73, 7'h11, 7'h11, 7'h11, 7'h11};
	// The spare opcode in row A of this table is the no-operation alias.
	localparam cit_entry_t CIT_TBL_N5 [16] = '{7'h22, 7'h22, 7'h22, 7'h22, 7'h22, 7'h22,
		7'h22, 7'h33, 7'h33, 7'h22, 7'h11, 7'h74, 7'h22, 7'h73, 7'h22, 7'h22};
	localparam cit_entry_t CIT_TBL_NI [16] = '{7'h12, 7'h12, 7'h12, 7'h12, 7'h12, 7'h12,
		7'h12, 7'h22, 7'h22, 7'h12, 7'h22, 7'h74, 7'h12, 7'h12, 7'h12, 7'h12};
	localparam cit_entry_t CIT_TBL_NR [16] = '{7'h11, 7'h11, 7'h11, 7'h11, 7'h11, 7'h11,
		7'h11, 7'h22, 7'h22, 7'h11, 7'h22, 7'h73, 7'h11, 7'h62, 7'h11, 7'h11};
endpackage : cit_pkg

// ==== shared/cit_dec_if.sv ====
// Purpose: Carries an opcode to the decoder and its timing back to the sequencer.
// Assumes: Purely combinational lookup.
// Notes: None.
`timescale 1ns/1ps
interface cit_dec_if;
	logic [7:0] opcode;
	logic [1:0] length;
	logic [3:0] cycles;
	logic cond;
	modport dec (input opcode, output length, output cycles, output cond);
	modport seq (output opcode, input length, input cycles, input cond);
endinterface : cit_dec_if

// ==== logic/cit_decode.sv ====
// Purpose: Maps an opcode to byte length, base cycle count and conditional flag.
// Assumes: Tables in the package are complete for all 256 opcodes.
// Notes: Base cycles of a conditional branch are its not-taken cost.
`timescale 1ns/1ps
module cit_decode
	import cit_pkg::*;
(
	// Lookup port
	cit_dec_if.dec dif
);
	wire [3:0] hi = dif.opcode[7:4];
	wire [3:0] lo = dif.opcode[3:0];
	wire is_ind = (lo[3:1] == CIT_LO_INDIRECT);
	cit_entry_t ent;
	// ==========================================================
	// Table selection
	assign ent = lo[3] ? CIT_TBL_NR[hi] :
		is_ind ? CIT_TBL_NI[hi] :
		(lo == CIT_LO_DIRECT) ? CIT_TBL_N5[hi] :
		(lo == CIT_LO_IMM) ? CIT_TBL_N4[hi] :
		(lo == CIT_LO_MISC) ? CIT_TBL_N3[hi] :
		(lo == CIT_LO_LONG) ? CIT_TBL_N2[hi] :
		(lo == CIT_LO_ABS) ? CIT_TBL_N1[hi] : CIT_TBL_N0[hi];
	assign dif.cycles = ent[3:0];
	assign dif.length = ent[5:4];
	assign dif.cond = ent[6];
endmodule : cit_decode

// ==== logic/cit_cycle_counter.sv ====
// Purpose: Loadable down counter of remaining instruction cycles.
// Assumes: Load has priority over decrement.
// Notes: The next value is exported so callers can register look-ahead outputs.
`timescale 1ns/1ps
module cit_cycle_counter #(
	parameter int W = 4
) (
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// Control
	input wire logic load,
	input wire logic [W-1:0] load_val,
	input wire logic dec,
	// State
	output logic [W-1:0] count,
	output logic [W-1:0] count_next
);
	logic [W-1:0] count_reg;
	assign count_next = load ? load_val : (dec ? count_reg - W'(1) : count_reg);
	assign count = count_reg;
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			count_reg <= '0;
		end else begin
			count_reg <= count_next;
		end
	end
endmodule : cit_cycle_counter

// ==== logic/cit_timing.sv ====
// Purpose: Sequences each instruction for exactly its documented number of clocks.
// Assumes: Opcode and branch resolution are synchronous to clk.
// Notes: A branch not resolved before its last base cycle counts as not taken.
// Overview of operation
// - Count plain clocks, no machine cycles.
// - Most instructions take cycles equal to bytes.
// - Untaken conditional branch is one cycle shorter.
// - Register with accumulator ALU: one byte, one cycle.
// - Indirect RAM ALU and inc/dec: 1 byte, 2 cycles.
// - Accumulator ALU direct or immediate: 2/2.
// - Logic immediate into direct byte: 3/3.
// - Logic accumulator into direct byte: 2/2.
// - Single-operand accumulator ops: one byte, one cycle.
// - Code byte reads: one byte, three cycles.
// - External data moves: one byte, three cycles.
// - Load data pointer immediate: three bytes, three cycles.
// - Push and pop direct: two bytes, two cycles.
// - Low nibble exchange indirect: one byte, two cycles.
// - Indirect RAM to direct byte: 2/2.
// - Direct to direct copy: three bytes, three cycles.
// - Direct byte to working register: 2/2.
// - Accumulator to indirect RAM: one byte, two cycles.
// - Immediate to indirect RAM: two bytes, two cycles.
// - Accumulator zero jumps: two or three cycles.
// - Spare opcode behaves as no-operation.
`timescale 1ns/1ps
module cit_timing
	import cit_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// Instruction issue
	input wire logic op_valid,
	input wire logic [7:0] opcode,
	output logic op_ready,
	// Branch resolution
	input wire logic cond_valid,
	input wire logic cond_taken,
	// Timing report
	output logic [CIT_LEN_W-1:0] instr_len,
	output logic [CIT_CYC_W-1:0] base_cycles,
	output logic [CIT_CYC_W-1:0] total_cycles,
	output logic cond_branch,
	output logic branch_taken,
	output logic busy,
	output logic instr_done
);
	// ==========================================================
	// Declarations
	cit_dec_if dif ();
	cit_state_t state_reg;
	cit_state_t state_next;
	logic op_ready_reg;
	logic op_ready_next;
	logic [CIT_LEN_W-1:0] len_reg;
	logic [CIT_LEN_W-1:0] len_next;
	logic [CIT_CYC_W-1:0] base_reg;
	logic [CIT_CYC_W-1:0] base_next;
	logic [CIT_CYC_W-1:0] total_reg;
	logic [CIT_CYC_W-1:0] total_next;
	logic cond_reg;
	logic cond_next;
	logic taken_reg;
	logic taken_next;
	logic busy_reg;
	logic busy_next;
	logic done_reg;
	logic done_next;
	logic [CIT_CYC_W-1:0] remain;
	logic [CIT_CYC_W-1:0] remain_next;
	wire accept;
	wire last_base;
	wire sample;
	wire go_extra;
	wire count_dec;

	// ==========================================================
	// Decode
	assign dif.opcode = opcode;
	cit_decode u_decode (
		.dif(dif)
	);

	// ==========================================================
	// Cycle counting
	// Accepting in the done cycle keeps back-to-back issue free of bubbles.
	assign accept = op_valid && op_ready_reg;
	assign last_base = (state_reg == CIT_EXEC) && (remain == CIT_CYC_1);
	// Resolution is only taken before the last base cycle so the length is known a cycle early.
	assign sample = (state_reg == CIT_EXEC) && !last_base && cond_reg && cond_valid;
	assign go_extra = last_base && cond_reg && taken_reg;
	assign count_dec = (state_reg == CIT_EXEC) && !last_base;

	cit_cycle_counter #(
		.W(CIT_CYC_W)
	) u_remain (
		.clk(clk),
		.reset_n(reset_n),
		.load(accept),
		.load_val(dif.cycles),
		.dec(count_dec),
		.count(remain),
		.count_next(remain_next)
	);

	// ==========================================================
	// Sequencer state
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			CIT_IDLE: begin
				if (accept) begin
					state_next = CIT_EXEC;
				end
			end
			CIT_EXEC: begin
				if (go_extra) begin
					state_next = CIT_EXTRA;
				end else if (last_base) begin
					state_next = accept ? CIT_EXEC : CIT_IDLE;
				end
			end
			CIT_EXTRA: begin
				state_next = accept ? CIT_EXEC : CIT_IDLE;
			end
			default: begin
				state_next = CIT_IDLE;
			end
		endcase
	end

	// ==========================================================
	// Look-ahead values for registered outputs
	assign len_next = accept ? dif.length : len_reg;
	assign base_next = accept ? dif.cycles : base_reg;
	assign cond_next = accept ? dif.cond : cond_reg;
	assign taken_next = accept ? 1'b0 : (sample ? cond_taken : taken_reg);
	assign total_next = accept ? dif.cycles :
		(go_extra ? total_reg + CIT_CYC_1 : total_reg);
	assign done_next = ((state_next == CIT_EXEC) && (remain_next == CIT_CYC_1) &&
		!(cond_next && taken_next)) || (state_next == CIT_EXTRA);
	assign op_ready_next = (state_next == CIT_IDLE) || done_next;
	assign busy_next = (state_next != CIT_IDLE);

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state_reg <= CIT_IDLE;
			op_ready_reg <= 1'b1;
			len_reg <= CIT_LEN_1;
			base_reg <= CIT_CYC_1;
			total_reg <= CIT_CYC_1;
			cond_reg <= 1'b0;
			taken_reg <= 1'b0;
			busy_reg <= 1'b0;
			done_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			op_ready_reg <= op_ready_next;
			len_reg <= len_next;
			base_reg <= base_next;
			total_reg <= total_next;
			cond_reg <= cond_next;
			taken_reg <= taken_next;
			busy_reg <= busy_next;
			done_reg <= done_next;
		end
	end

	// ==========================================================
	// Outputs
	assign op_ready = op_ready_reg;
	assign instr_len = len_reg;
	assign base_cycles = base_reg;
	assign total_cycles = total_reg;
	assign cond_branch = cond_reg;
	assign branch_taken = taken_reg;
	assign busy = busy_reg;
	assign instr_done = done_reg;

	// ==========================================================
	// Checks
	logic [CIT_CYC_W-1:0] elapsed_reg;
	logic [7:0] last_op_reg;
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			elapsed_reg <= CIT_CYC_0;
			last_op_reg <= 8'h00;
		end else begin
			elapsed_reg <= accept ? CIT_CYC_1 : elapsed_reg + CIT_CYC_1;
			last_op_reg <= accept ? opcode : last_op_reg;
		end
	end

	wire [3:0] op_hi = opcode[7:4];
	wire [3:0] op_lo = opcode[3:0];
	wire alu_row = (op_hi >= 4'h2 && op_hi <= 4'h6) || (op_hi == 4'h9);

	a_clock_count_exact: assert property (@(posedge clk) disable iff (!reset_n)
		instr_done |-> elapsed_reg == total_cycles)
		else $error("instruction length in clocks differs from its total");

	a_untaken_equals_base: assert property (@(posedge clk) disable iff (!reset_n)
		instr_done && !branch_taken |-> total_cycles == base_cycles)
		else $error("untaken or plain instruction ran other than base cycles");

	a_taken_adds_one: assert property (@(posedge clk) disable iff (!reset_n)
		instr_done && branch_taken |-> cond_branch && total_cycles == base_cycles + CIT_CYC_1)
		else $error("taken branch did not cost exactly one more cycle");

	a_reg_alu_timing: assert property (@(posedge clk) disable iff (!reset_n)
		accept && alu_row && op_lo[3] |=> instr_len == CIT_LEN_1 && base_cycles == CIT_CYC_1)
		else $error("register alu op has wrong timing");

	a_ind_alu_timing: assert property (@(posedge clk) disable iff (!reset_n)
		accept && (alu_row || op_hi <= 4'h1) && op_lo[3:1] == CIT_LO_INDIRECT
		|=> instr_len == CIT_LEN_1 && base_cycles == CIT_CYC_2)
		else $error("indirect alu op has wrong timing");

	a_dir_imm_alu: assert property (@(posedge clk) disable iff (!reset_n)
		accept && alu_row && (op_lo == CIT_LO_IMM || op_lo == CIT_LO_DIRECT)
		|=> instr_len == CIT_LEN_2 && base_cycles == CIT_CYC_2)
		else $error("direct or immediate alu op has wrong timing");

	a_logic_dir_imm: assert property (@(posedge clk) disable iff (!reset_n)
		accept && op_lo == CIT_LO_MISC && op_hi >= 4'h4 && op_hi <= 4'h6
		|=> instr_len == CIT_LEN_3 && base_cycles == CIT_CYC_3)
		else $error("logic immediate to direct has wrong timing");

	a_code_ext_read: assert property (@(posedge clk) disable iff (!reset_n)
		accept && (opcode == 8'h83 || opcode == 8'h93 || (op_hi >= 4'he && op_lo <= 4'h3 &&
		op_lo != CIT_LO_ABS)) |=> instr_len == CIT_LEN_1 && base_cycles == CIT_CYC_3)
		else $error("code or external data access has wrong timing");

	a_acc_to_ind: assert property (@(posedge clk) disable iff (!reset_n)
		accept && op_hi == 4'hf && op_lo[3:1] == CIT_LO_INDIRECT
		|=> instr_len == CIT_LEN_1 && base_cycles == CIT_CYC_2 && !cond_branch)
		else $error("accumulator to indirect has wrong timing");

	a_zero_jump: assert property (@(posedge clk) disable iff (!reset_n)
		accept && (opcode == 8'h60 || opcode == 8'h70)
		|=> cond_branch && instr_len == CIT_LEN_2 && base_cycles == CIT_CYC_2)
		else $error("zero jump has wrong timing");

	a_spare_is_nop: assert property (@(posedge clk) disable iff (!reset_n)
		accept && opcode == CIT_OP_ALIAS_NOP
		|=> instr_len == CIT_LEN_1 && base_cycles == CIT_CYC_1 && !cond_branch ##0
		instr_done)
		else $error("spare opcode does not act as no-operation");

	a_busy_until_done: assert property (@(posedge clk) disable iff (!reset_n)
		accept |=> busy throughout (busy ##[0:8] instr_done))
		else $error("instruction did not finish within bound");

	c_back_to_back: cover property (@(posedge clk) disable iff (!reset_n)
		instr_done && accept ##1 busy);
	c_taken_branch: cover property (@(posedge clk) disable iff (!reset_n)
		instr_done && branch_taken);
	c_untaken_branch: cover property (@(posedge clk) disable iff (!reset_n)
		instr_done && cond_branch && !branch_taken);
	c_longest_op: cover property (@(posedge clk) disable iff (!reset_n)
		instr_done && total_cycles == CIT_CYC_8);
endmodule : cit_timing

// ==== test/cit_timing_tb.sv ====
// Purpose: Self-checking bench for the instruction timing block.
// Assumes: One 250 MHz clock; outputs settle within the cycle after each edge.
// Notes: The driver queues expectations, the monitor pops one per completed instruction.
`timescale 1ns/1ps
module cit_timing_tb;
	import cit_pkg::*;
	// ==========================================================
	// Types, signals and counters
	typedef struct packed {
		logic cond;
		logic [1:0] len;
		logic [3:0] cyc;
	} cit_tb_spec_t;
	typedef struct {
		cit_tb_spec_t s;
		logic taken;
		logic [3:0] total;
		time t0;
	} cit_tb_note_t;
	logic clk;
	logic reset_n;
	logic op_valid;
	logic [7:0] opcode;
	logic op_ready;
	logic cond_valid;
	logic cond_taken;
	logic [CIT_LEN_W-1:0] instr_len;
	logic [CIT_CYC_W-1:0] base_cycles;
	logic [CIT_CYC_W-1:0] total_cycles;
	logic cond_branch;
	logic branch_taken;
	logic busy;
	logic instr_done;
	int failures = 0;
	int compares = 0;
	int seed = 9098;
	cit_tb_note_t notes[$];
	logic [7:0] ops[$];
	cit_timing uut (
		.clk(clk), .reset_n(reset_n), .op_valid(op_valid), .opcode(opcode),
		.op_ready(op_ready), .cond_valid(cond_valid), .cond_taken(cond_taken),
		.instr_len(instr_len), .base_cycles(base_cycles), .total_cycles(total_cycles),
		.cond_branch(cond_branch), .branch_taken(branch_taken), .busy(busy),
		.instr_done(instr_done)
	);
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	// ==========================================================
	// Expected timing per opcode; zero marks an opcode outside the checked set
	function automatic cit_tb_spec_t spec(input logic [7:0] op);
		case (op)
			8'h28, 8'h38, 8'h98, 8'h58, 8'h48, 8'h68: spec = 7'h11;
			8'he4, 8'hf4, 8'h23, 8'h33, 8'h03, 8'h13, 8'hc4: spec = 7'h11;
			8'ha5, 8'h00: spec = 7'h11;
			8'h26, 8'h06, 8'h16: spec = 7'h12;
			8'hd6: spec = 7'h12;
			8'hf6: spec = 7'h12;
			8'h25, 8'h24: spec = 7'h22;
			8'h52, 8'h42, 8'h62: spec = 7'h22;
			8'hc0, 8'hd0: spec = 7'h22;
			8'h86: spec = 7'h22;
			8'ha8: spec = 7'h22;
			8'h76: spec = 7'h22;
			8'h53, 8'h43, 8'h63: spec = 7'h33;
			8'h90: spec = 7'h33;
			8'h85: spec = 7'h33;
			8'h93, 8'h83: spec = 7'h13;
			8'he2, 8'hf2, 8'he0, 8'hf0: spec = 7'h13;
			8'h60, 8'h70: spec = 7'h62;
			default: spec = 7'h00;
		endcase
	endfunction : spec
	// ==========================================================
	// Shared tasks
	task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
		compares++;
		if (got !== exp) begin
			failures++;
			$display("ERROR %s expected %0h seen %0h", what, exp, got);
		end
	endtask : check
	task automatic finish_test;
		$display("compares=%0d failures=%0d", compares, failures);
		if (failures == 0 && compares > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : finish_test
	// Checks the idle state, then returns on a rising edge.
	task automatic check_idle;
		#1;
		check("op_ready", 8'h1, 8'(op_ready));
		check("instr_len", 8'h1, 8'(instr_len));
		check("base_cycles", 8'h1, 8'(base_cycles));
		check("total_cycles", 8'h1, 8'(total_cycles));
		check("flags", 8'h0, {4'h0, cond_branch, branch_taken, busy, instr_done});
		@(posedge clk);
	endtask : check_idle
	// Offers one opcode; with cvc > 0 the resolution is driven in cycle cvc.
	// With cvc = 0 op_valid is left high so the caller can issue back to back.
	task automatic issue(input logic [7:0] op, input int cvc, input logic tk);
		cit_tb_note_t n;
		op_valid <= 1'b1;
		opcode <= op;
		do @(posedge clk); while (op_ready !== 1'b1);
		n.s = spec(op);
		n.taken = n.s.cond && cvc >= 1 && cvc < int'(n.s.cyc) && tk;
		n.total = n.s.cyc + 4'(n.taken);
		n.t0 = $time;
		notes.push_back(n);
		for (int k = 0; k < cvc; k++) begin
			cond_valid <= (k == cvc - 1);
			cond_taken <= tk;
			if (k == 0) begin
				op_valid <= 1'b0;
			end
			@(posedge clk);
		end
		if (cvc > 0) begin
			cond_valid <= 1'b0;
		end
	endtask : issue
	task automatic go_idle(input int n);
		op_valid <= 1'b0;
		repeat (n) @(posedge clk);
	endtask : go_idle
	// ==========================================================
	// Monitor: one note per completed instruction
	always @(posedge clk) begin
		cit_tb_note_t n;
		if (reset_n === 1'b1 && instr_done === 1'b1) begin
			if (notes.size() == 0) begin
				failures++;
				$display("ERROR instr_done expected 0 seen 1");
			end else begin
				n = notes.pop_front();
				check("cycles", 8'(n.total), 8'(($time - n.t0) / 4));
				check("instr_len", 8'(n.s.len), 8'(instr_len));
				check("base_cycles", 8'(n.s.cyc), 8'(base_cycles));
				check("total_cycles", 8'(n.total), 8'(total_cycles));
				check("cond_branch", 8'(n.s.cond), 8'(cond_branch));
				check("branch_taken", 8'(n.taken), 8'(branch_taken));
				check("op_ready", 8'h1, 8'(op_ready));
				check("busy", 8'h1, 8'(busy));
			end
		end
	end
	// ==========================================================
	// Watchdog: the whole run needs a few thousand cycles at most.
	initial begin
		#100000;
		failures++;
		$display("ERROR watchdog expected finish seen timeout");
		finish_test();
	end
	// ==========================================================
	// Main sequence
	initial begin
		int idx;
		reset_n = 1'b0;
		op_valid = 1'b0;
		opcode = 8'h00;
		cond_valid = 1'b0;
		cond_taken = 1'b0;
		for (int o = 0; o < 256; o++) begin
			if (spec(o[7:0]) != 7'h00) begin
				ops.push_back(o[7:0]);
			end
		end
		repeat (8) @(posedge clk);
		reset_n <= 1'b1;
		@(posedge clk);
		check_idle();
		// Every listed opcode, back to back.
		foreach (ops[i]) begin
			issue(ops[i], 0, 1'b0);
		end
		go_idle(4);
		// Branches taken, not taken, late, unresolved; a resolution on a non-branch.
		issue(8'h60, 1, 1'b1);
		issue(8'h60, 1, 1'b0);
		issue(8'h70, 1, 1'b1);
		issue(8'h70, 2, 1'b1);
		issue(8'h70, 0, 1'b1);
		go_idle(1);
		issue(8'h24, 1, 1'b1);
		go_idle(4);
		// Random mix with random resolutions.
		repeat (200) begin
			idx = int'($unsigned($random(seed)) % ops.size());
			issue(ops[idx], int'($unsigned($random(seed)) % 2), 1'($random(seed)));
		end
		go_idle(8);
		check("pending", 8'h0, 8'(notes.size()));
		// Reset in the middle of a three-cycle instruction.
		issue(8'h90, 0, 1'b0);
		@(posedge clk);
		reset_n <= 1'b0;
		op_valid <= 1'b0;
		notes.delete();
		check_idle();
		reset_n <= 1'b1;
		@(posedge clk);
		check_idle();
		issue(8'ha5, 0, 1'b0);
		go_idle(4);
		check("pending", 8'h0, 8'(notes.size()));
		finish_test();
	end
endmodule : cit_timing_tb
